// >>> logic/sce_pkg.sv
// Constants and types for the serial EEPROM command engine.
package sce_pkg;
    localparam logic [7:0] OPCODE_MASK           = 8'hf7;
    localparam logic [7:0] set_write_latch_cmd   = 8'h06;
    localparam logic [7:0] clear_write_latch_cmd = 8'h04;
    localparam logic [7:0] status_read_cmd       = 8'h05;
    localparam logic [7:0] status_write_cmd      = 8'h01;
    localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD       = 8'h02;
    localparam int         TOP_ADDRESS_POS       = 3;
    localparam int         PROTECT_LOWER_POS     = 2;
    localparam logic [3:0] STATUS_FIXED_ONES     = 4'hf;
    localparam int         PAGE_BYTES            = 16;
    localparam int         PAGE_AW               = 4;
    localparam int         ADDR_BITS             = 9;
    localparam logic [1:0] PROTECT_RESET         = 2'h0;
    localparam logic [1:0] PROT_NONE             = 2'h0;
    localparam logic [1:0] PROT_QUARTER          = 2'h1;
    localparam logic [1:0] PROT_HALF             = 2'h2;
    localparam logic [4:0] DATA_COUNT_MAX        = 5'h1f;
    localparam logic [7:0] ERASED_BYTE           = 8'h00;
    localparam int         CLK_FREQ_MHZ          = 20;
    localparam int         SELF_TIMED_WRITE_TIME_US = 5000;
    localparam int         SELF_TIMED_WRITE_CYCLES  =
        SELF_TIMED_WRITE_TIME_US * CLK_FREQ_MHZ;

    typedef enum logic [3:0]
    {
        LM_CMD,
        LM_ADDR_RD,
        LM_ADDR_WR,
        LM_STATUS,
        LM_SR_DATA,
        LM_SR_DONE,
        LM_RD_DATA,
        LM_WR_DATA,
        LM_WAIT
    } sce_mode_type;

    typedef enum logic [1:0]
    {
        WC_IDLE,
        WC_ERASE,
        WC_PROGRAM
    } sce_wcyc_type;
endpackage : sce_pkg

// >>> logic/sce_engine.sv
`timescale 1ns/1ps
// Serial EEPROM command engine with link shifter and timed write cycle.
module sce_engine
#(
    parameter int ADDR_W    = sce_pkg::ADDR_BITS,
    parameter int TW_CYCLES = sce_pkg::SELF_TIMED_WRITE_CYCLES
)
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic spi_cs_n,
    input  wire logic spi_sclk,
    input  wire logic spi_mosi,
    input  wire logic wp_n,
    output logic      spi_miso,
    output logic      spi_miso_oe
);
    localparam int DEPTH  = 1 << ADDR_W;
    localparam int PG_W   = ADDR_W - sce_pkg::PAGE_AW;
    localparam int CNT_W  = $clog2(TW_CYCLES + 1);
    localparam logic [CNT_W-1:0] T_LAST = CNT_W'(TW_CYCLES - 1);
    localparam logic [CNT_W-1:0] T_HALF = CNT_W'(TW_CYCLES / 2);

    logic                       link_rst;
    logic                       fresh_r;
    logic                       frame_tgl_r;
    logic [2:0]                 bit_r;
    logic [2:0]                 bit_cur;
    logic [6:0]                 shift_r;
    logic [7:0]                 rx_byte;
    logic                       byte_done;
    sce_pkg::sce_mode_type      mode_r;
    sce_pkg::sce_mode_type      mode_cur;
    sce_pkg::sce_mode_type      mode_nxt;
    logic [7:0]                 cmd_r;
    logic [7:0]                 sr_data_r;
    logic [ADDR_W-1:0]          addr_r;
    logic [4:0]                 dcount_r;
    logic [3:0]                 wr_slot;
    logic [7:0]                 page_buf_r [0:sce_pkg::PAGE_BYTES-1];
    logic [sce_pkg::PAGE_BYTES-1:0] page_mask_r;
    logic [3:0]                 stat_s1_r;
    logic [3:0]                 stat_s2_r;
    logic [7:0]                 status_byte;
    logic [7:0]                 src_byte;
    logic [7:0]                 tx_byte_r;
    logic                       miso_r;
    logic                       miso_oe_r;
    logic                       tx_drive;

    logic [7:0]                 mem_r [0:DEPTH-1];
    logic                       cs_s1_r;
    logic                       cs_s2_r;
    logic                       cs_s3_r;
    logic                       wp_s1_r;
    logic                       wp_s2_r;
    logic                       tgl_s1_r;
    logic                       tgl_s2_r;
    logic                       tgl_seen_r;
    logic                       wp_low_seen_r;
    logic                       frame_end;
    logic                       exec_ok;
    logic                       wp_bad;
    logic [7:0]                 cmd_masked;
    logic                       do_set;
    logic                       do_clear;
    logic                       prot_hit;
    logic                       start_sr;
    logic                       start_wr;
    logic                       cycle_done;
    sce_pkg::sce_wcyc_type      wcyc_r;
    logic [CNT_W-1:0]           timer_r;
    logic                       wr_is_status_r;
    logic [1:0]                 protect_pending_r;
    logic [PG_W-1:0]            commit_page_r;
    logic [sce_pkg::PAGE_BYTES-1:0] commit_mask_r;
    logic [7:0]                 commit_buf_r [0:sce_pkg::PAGE_BYTES-1];
    logic                       write_in_progress_r;
    logic                       write_enable_latch_r;
    logic                       protect_upper_bit_r;
    logic                       protect_lower_bit_r;

    function automatic logic prot_lookup(input logic [1:0] bp,
                                         input logic [1:0] top);
        logic hit;
        case (bp)
            sce_pkg::PROT_NONE:    hit = 1'b0;
            sce_pkg::PROT_QUARTER: hit = (top == 2'h3);
            sce_pkg::PROT_HALF:    hit = top[1];
            default:               hit = 1'b1;
        endcase
        return hit;
    endfunction : prot_lookup

    // Link logic is held in its frame state while chip select is high.
    assign link_rst  = spi_cs_n | sys_rst;
    assign bit_cur   = fresh_r ? 3'h0 : bit_r;
    assign mode_cur  = fresh_r ? sce_pkg::LM_CMD : mode_r;
    assign rx_byte   = {(fresh_r ? 7'h00 : shift_r), spi_mosi};
    assign byte_done = (bit_cur == 3'h7);
    assign wr_slot   = addr_r[3:0] + dcount_r[3:0];

    always_ff @(posedge spi_sclk or posedge link_rst)
    begin
        if (link_rst)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    always_comb
    begin
        mode_nxt = mode_cur;
        if (byte_done)
        begin
            case (mode_cur)
                sce_pkg::LM_CMD:
                begin
                    if ((rx_byte & sce_pkg::OPCODE_MASK) ==
                        sce_pkg::ARRAY_READ_CMD)
                        mode_nxt = stat_s2_r[0] ? sce_pkg::LM_WAIT
                                                : sce_pkg::LM_ADDR_RD;
                    else if ((rx_byte & sce_pkg::OPCODE_MASK) ==
                             sce_pkg::ARRAY_WRITE_CMD)
                        mode_nxt = sce_pkg::LM_ADDR_WR;
                    else if ((rx_byte & sce_pkg::OPCODE_MASK) ==
                             sce_pkg::status_read_cmd)
                        mode_nxt = sce_pkg::LM_STATUS;
                    else if ((rx_byte & sce_pkg::OPCODE_MASK) ==
                             sce_pkg::status_write_cmd)
                        mode_nxt = sce_pkg::LM_SR_DATA;
                    else
                        mode_nxt = sce_pkg::LM_WAIT;
                end
                sce_pkg::LM_ADDR_RD: mode_nxt = sce_pkg::LM_RD_DATA;
                sce_pkg::LM_ADDR_WR: mode_nxt = sce_pkg::LM_WR_DATA;
                sce_pkg::LM_SR_DATA: mode_nxt = sce_pkg::LM_SR_DONE;
                sce_pkg::LM_SR_DONE: mode_nxt = sce_pkg::LM_WAIT;
                default:             mode_nxt = mode_cur;
            endcase
        end
    end

    always_ff @(posedge spi_sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bit_r       <= 3'h0;
            shift_r     <= 7'h00;
            mode_r      <= sce_pkg::LM_CMD;
            frame_tgl_r <= 1'b0;
        end
        else
        begin
            bit_r   <= bit_cur + 3'h1;
            shift_r <= rx_byte[6:0];
            mode_r  <= mode_nxt;
            if (fresh_r)
                frame_tgl_r <= ~frame_tgl_r;
        end
    end

    always_ff @(posedge spi_sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_r     <= 8'h00;
            sr_data_r <= 8'h00;
        end
        else if (byte_done && mode_cur == sce_pkg::LM_CMD)
            cmd_r <= rx_byte;
        else if (byte_done && mode_cur == sce_pkg::LM_SR_DATA)
            sr_data_r <= rx_byte;
    end

    always_ff @(posedge spi_sclk or posedge sys_rst)
    begin
        if (sys_rst)
            addr_r <= '0;
        else if (byte_done && (mode_cur == sce_pkg::LM_ADDR_RD ||
                               mode_cur == sce_pkg::LM_ADDR_WR))
            addr_r <= ADDR_W'({cmd_r[sce_pkg::TOP_ADDRESS_POS], rx_byte});
        else if (byte_done && mode_cur == sce_pkg::LM_RD_DATA)
            addr_r <= addr_r + 1'b1;
    end

    always_ff @(posedge spi_sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dcount_r    <= 5'h00;
            page_mask_r <= '0;
        end
        else if (byte_done && mode_cur == sce_pkg::LM_CMD)
        begin
            dcount_r    <= 5'h00;
            page_mask_r <= '0;
        end
        else if (byte_done && mode_cur == sce_pkg::LM_WR_DATA)
        begin
            page_mask_r[wr_slot] <= 1'b1;
            if (dcount_r != sce_pkg::DATA_COUNT_MAX)
                dcount_r <= dcount_r + 5'h01;
        end
    end

    always_ff @(posedge spi_sclk)
    begin
        if (byte_done && mode_cur == sce_pkg::LM_WR_DATA)
            page_buf_r[wr_slot] <= rx_byte;
    end

    always_ff @(posedge spi_sclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stat_s1_r <= 4'h0;
            stat_s2_r <= 4'h0;
        end
        else
        begin
            stat_s1_r <= {protect_upper_bit_r, protect_lower_bit_r,
                          write_enable_latch_r, write_in_progress_r};
            stat_s2_r <= stat_s1_r;
        end
    end

    assign status_byte = {sce_pkg::STATUS_FIXED_ONES, stat_s2_r};
    assign src_byte    = (mode_r == sce_pkg::LM_STATUS) ? status_byte
                                                        : mem_r[addr_r];
    assign tx_drive    = !fresh_r && (mode_r == sce_pkg::LM_STATUS ||
                                      mode_r == sce_pkg::LM_RD_DATA);

    always_ff @(negedge spi_sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            miso_r    <= 1'b0;
            miso_oe_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end
        else
        begin
            miso_oe_r <= tx_drive;
            if (bit_r == 3'h0)
            begin
                tx_byte_r <= src_byte;
                miso_r    <= tx_drive & src_byte[7];
            end
            else
                miso_r <= tx_drive & tx_byte_r[3'h7 - bit_r];
        end
    end

    assign spi_miso    = miso_r;
    assign spi_miso_oe = miso_oe_r;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_s1_r  <= 1'b1;
            cs_s2_r  <= 1'b1;
            cs_s3_r  <= 1'b1;
            wp_s1_r  <= 1'b1;
            wp_s2_r  <= 1'b1;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
        end
        else
        begin
            cs_s1_r  <= spi_cs_n;
            cs_s2_r  <= cs_s1_r;
            cs_s3_r  <= cs_s2_r;
            wp_s1_r  <= wp_n;
            wp_s2_r  <= wp_s1_r;
            tgl_s1_r <= frame_tgl_r;
            tgl_s2_r <= tgl_s1_r;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tgl_seen_r    <= 1'b0;
            wp_low_seen_r <= 1'b0;
        end
        else if (frame_end)
        begin
            tgl_seen_r    <= tgl_s2_r;
            wp_low_seen_r <= 1'b0;
        end
        else if (!cs_s2_r && !wp_s2_r)
            wp_low_seen_r <= 1'b1;
    end

    // frame ends on chip select rise
    assign frame_end  = cs_s2_r & ~cs_s3_r;
    assign exec_ok    = frame_end && (tgl_s2_r != tgl_seen_r) &&
                        (bit_r == 3'h0);
    assign wp_bad     = wp_low_seen_r | ~wp_s2_r;
    assign cmd_masked = cmd_r & sce_pkg::OPCODE_MASK;
    assign do_set     = exec_ok && mode_r == sce_pkg::LM_WAIT &&
                        cmd_masked == sce_pkg::set_write_latch_cmd;
    assign do_clear   = exec_ok && mode_r == sce_pkg::LM_WAIT &&
                        cmd_masked == sce_pkg::clear_write_latch_cmd;
    assign prot_hit   = prot_lookup({protect_upper_bit_r,
                                     protect_lower_bit_r},
                                    addr_r[ADDR_W-1 -: 2]);
    assign start_sr   = exec_ok && mode_r == sce_pkg::LM_SR_DONE &&
                        write_enable_latch_r && !write_in_progress_r &&
                        !wp_bad;
    assign start_wr   = exec_ok && mode_r == sce_pkg::LM_WR_DATA &&
                        dcount_r != 5'h00 && write_enable_latch_r &&
                        !write_in_progress_r && !wp_bad && !prot_hit;
    assign cycle_done = (wcyc_r == sce_pkg::WC_PROGRAM) &&
                        (timer_r == T_LAST);

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wcyc_r              <= sce_pkg::WC_IDLE;
            timer_r             <= '0;
            write_in_progress_r <= 1'b0;
        end
        else
        begin
            case (wcyc_r)
                sce_pkg::WC_IDLE:
                begin
                    timer_r <= '0;
                    if (start_sr || start_wr)
                    begin
                        wcyc_r              <= sce_pkg::WC_ERASE;
                        write_in_progress_r <= 1'b1;
                    end
                end
                sce_pkg::WC_ERASE:
                begin
                    timer_r <= timer_r + 1'b1;
                    if (timer_r == T_HALF - 1'b1)
                        wcyc_r <= sce_pkg::WC_PROGRAM;
                end
                sce_pkg::WC_PROGRAM:
                begin
                    timer_r <= timer_r + 1'b1;
                    if (cycle_done)
                    begin
                        wcyc_r              <= sce_pkg::WC_IDLE;
                        write_in_progress_r <= 1'b0;
                    end
                end
                default:
                begin
                    wcyc_r              <= sce_pkg::WC_IDLE;
                    write_in_progress_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_is_status_r    <= 1'b0;
            protect_pending_r <= 2'h0;
            commit_page_r     <= '0;
            commit_mask_r     <= '0;
        end
        else if (wcyc_r == sce_pkg::WC_IDLE && (start_sr || start_wr))
        begin
            wr_is_status_r    <= start_sr;
            protect_pending_r <=
                sr_data_r[sce_pkg::PROTECT_LOWER_POS +: 2];
            commit_page_r     <= addr_r[ADDR_W-1:sce_pkg::PAGE_AW];
            commit_mask_r     <= start_wr ? page_mask_r : '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (wcyc_r == sce_pkg::WC_IDLE && start_wr)
            commit_buf_r <= page_buf_r;
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < sce_pkg::PAGE_BYTES; i++)
        begin
            if (commit_mask_r[i] && wcyc_r == sce_pkg::WC_ERASE &&
                timer_r == '0)
                mem_r[{commit_page_r, sce_pkg::PAGE_AW'(i)}] <=
                    sce_pkg::ERASED_BYTE;
            else if (commit_mask_r[i] && wcyc_r == sce_pkg::WC_PROGRAM &&
                     timer_r == T_HALF)
                mem_r[{commit_page_r, sce_pkg::PAGE_AW'(i)}] <=
                    commit_buf_r[i];
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            write_enable_latch_r <= 1'b0;
        else if (!wp_s2_r)
            write_enable_latch_r <= 1'b0;
        else if (do_set)
            write_enable_latch_r <= 1'b1;
        else if (do_clear || cycle_done)
            write_enable_latch_r <= 1'b0;
    end

    // protect bits change only at completion of a status write
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            protect_upper_bit_r <= sce_pkg::PROTECT_RESET[1];
            protect_lower_bit_r <= sce_pkg::PROTECT_RESET[0];
        end
        else if (cycle_done && wr_is_status_r)
        begin
            protect_upper_bit_r <= protect_pending_r[1];
            protect_lower_bit_r <= protect_pending_r[0];
        end
    end
endmodule : sce_engine

// >>> bench/sce_chk.sv
// Link checker for the serial EEPROM command engine.
`timescale 1ns/1ps
module sce_chk
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    logic [15:0] cnt_r;
    logic [7:0]  op_r;
    logic        st_rd;
    logic        ar_rd;
    always_ff @(posedge spi_sclk or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            cnt_r <= 16'h0000;
        else if (cnt_r != 16'hffff)
            cnt_r <= cnt_r + 16'h0001;
    end
    always_ff @(posedge spi_sclk)
    begin
        if (cnt_r < 16'h0008)
            op_r <= {op_r[6:0], spi_mosi};
    end
    assign st_rd = (op_r & sce_pkg::OPCODE_MASK) == sce_pkg::status_read_cmd;
    assign ar_rd = (op_r & sce_pkg::OPCODE_MASK) == sce_pkg::ARRAY_READ_CMD;
    a_oe_off_deselect: assert property (@(posedge clock)
        disable iff (sys_rst) spi_cs_n |-> !spi_miso_oe) else $error("oe on");
    a_idle_miso_low: assert property (@(posedge clock)
        disable iff (sys_rst) !spi_miso_oe |-> !spi_miso) else $error("miso");
    a_oe_until_deselect: assert property (@(posedge clock)
        disable iff (sys_rst) $fell(spi_miso_oe) |-> spi_cs_n)
        else $error("oe dropped early");
    a_quiet_first_byte: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n) cnt_r < 16'h0008 |-> !spi_miso_oe)
        else $error("oe in command");
    a_status_driven: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n) st_rd && cnt_r > 16'h0007 |-> spi_miso_oe)
        else $error("status not driven");
    a_status_ones: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n) st_rd && cnt_r > 16'h0007 && !cnt_r[2]
        |-> spi_miso) else $error("status lead bits");
    a_silent_cmds: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n) !st_rd && !ar_rd && cnt_r > 16'h0007
        |-> !spi_miso_oe) else $error("oe on silent command");
    a_read_addr_quiet: assert property (@(posedge spi_sclk)
        disable iff (spi_cs_n) ar_rd && cnt_r < 16'h0010 |-> !spi_miso_oe)
        else $error("oe in address");
    c_stat: cover property (@(posedge spi_sclk) st_rd && cnt_r == 16'h0017);
    c_arr: cover property (@(posedge spi_sclk) ar_rd && spi_miso_oe);
    c_sel: cover property (@(posedge clock) $fell(spi_cs_n));
endmodule : sce_chk
bind sce_engine sce_chk sce_chk_inst (.clock(clock), .sys_rst(sys_rst),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

// >>> bench/sce_mst.sv
// Bus master model that runs link frames for the command engine.
`timescale 1ns/1ps
module sce_mst
(
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe
);
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic frame(input logic [39:0] d, input int n,
                         output logic [23:0] i);
        i = 24'h000000;
        spi_cs_n = 1'b0;
        for (int k = 39; k > 39 - n; k--)
        begin
            spi_mosi = d[k];
            #16 spi_sclk = 1'b1;
            i = {i[22:0], spi_miso_oe ? spi_miso : 1'b1};
            #16 spi_sclk = 1'b0;
        end
        #8 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #300;
    endtask : frame
endmodule : sce_mst

// >>> bench/sce_engine_bench.sv
// Self-checking bench for the serial EEPROM command engine.
`timescale 1ns/1ps
module sce_engine_bench;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b0;
    logic        wp_n = 1'b1;
    logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
    logic [23:0] r;
    int          fails = 0;
    int          checks = 0;
    always #25 clock = ~clock;
    sce_engine #(.TW_CYCLES(64)) sce_engine_inst (.clock(clock),
        .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .wp_n(wp_n), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    sce_mst sce_mst_inst (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
    task automatic chk(input logic [23:0] v, input logic [23:0] e);
        checks++;
        if (v !== e)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, v, e);
        end
    endtask : chk
    task automatic go(input logic [39:0] d, input int n);
        sce_mst_inst.frame(d, n, r);
    endtask : go
    task automatic sr(input logic [7:0] e);
        go({sce_pkg::status_read_cmd, 32'h0}, 24);
        chk(r, {8'hff, e, e});
    endtask : sr
    task automatic wr(input logic [8:0] a, input logic [23:0] d, input int n);
        go({sce_pkg::set_write_latch_cmd, 32'h0}, 8);
        go({sce_pkg::ARRAY_WRITE_CMD | {4'h0, a[8], 3'h0}, a[7:0], d}, n);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [23:0] e, input int n);
        go({sce_pkg::ARRAY_READ_CMD | {4'h0, a[8], 3'h0}, a[7:0], 24'h0}, n);
        chk(r, e);
    endtask : rd
    task automatic sw(input logic [7:0] d);
        go({sce_pkg::set_write_latch_cmd, 32'h0}, 8);
        go({sce_pkg::status_write_cmd, d, 24'h0}, 16);
    endtask : sw
    task automatic idle();
        for (int k = 0; k < 40; k++)
        begin
            go({sce_pkg::status_read_cmd, 32'h0}, 16);
            if (r[0] === 1'b0)
                return;
        end
        fails++;
        tally_and_finish();
    endtask : idle
    task automatic s_latch();
        sr(8'hf0);
        go({8'h0e, 32'h0}, 8);
        sr(8'hf2);
        go({8'h0c, 32'h0}, 8);
        sr(8'hf0);
        go({8'hff, 32'h0}, 16);
    endtask : s_latch
    task automatic s_write();
        wr(9'h000, 24'h5a0000, 24);
        sr(8'hf3);
        rd(9'h000, 24'hffffff, 24);
        idle();
        sr(8'hf0);
        wr(9'h1fe, 24'h112233, 40);
        idle();
        rd(9'h1fe, 24'h11225a, 40);
        rd(9'h1f0, 24'hffff33, 24);
    endtask : s_write
    task automatic s_refuse();
        go({sce_pkg::ARRAY_WRITE_CMD, 32'h00770000}, 24);
        sr(8'hf0);
        wr(9'h000, 24'h770000, 28);
        sr(8'hf2);
        @(negedge clock) wp_n = 1'b0;
        sr(8'hf0);
        wr(9'h000, 24'h770000, 24);
        sr(8'hf0);
        @(negedge clock) wp_n = 1'b1;
        wr(9'h000, 24'ha50000, 24);
        idle();
        rd(9'h000, 24'hffffa5, 24);
    endtask : s_refuse
    task automatic s_protect();
        sw(8'hff);
        idle();
        sr(8'hfc);
        wr(9'h000, 24'h770000, 24);
        sr(8'hfe);
        sw(8'h04);
        idle();
        sr(8'hf4);
        wr(9'h180, 24'h770000, 24);
        sr(8'hf6);
        wr(9'h17f, 24'h3c0000, 24);
        idle();
        rd(9'h17f, 24'hffff3c, 24);
        @(negedge clock) wp_n = 1'b0;
        sw(8'h00);
        @(negedge clock) wp_n = 1'b1;
        sr(8'hf4);
    endtask : s_protect
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        @(negedge clock) sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        s_latch();
        s_write();
        s_refuse();
        s_protect();
        tally_and_finish();
    end
endmodule : sce_engine_bench
